// ==== io_window_defines.svh ====
// constants for the io window decoder: address fields, offsets, jumper weights
// assumes a 10-bit isa i/o address and active-low bus strobes
`ifndef IO_WINDOW_DEFINES_SVH
`define IO_WINDOW_DEFINES_SVH

// ==========================================================
// address fields
`define ADDR_WIDTH        10
`define JUMPER_COUNT      6
`define BASE_FIELD_LSB    4
`define BASE_FIELD_MSB    9
`define SLOT_FIELD_LSB    2
`define SLOT_FIELD_MSB    3
`define WINDOW_BYTES      16

// ==========================================================
// sub-window slots (address bits 3:2)
`define SLOT_WIN0         2'h0
`define SLOT_WIN1         2'h1
`define SLOT_WRITE        2'h2
`define SLOT_READ         2'h3

// ==========================================================
// transfer-way levels and jumper default (0x300)
`define DIR_CARD_TO_HOST  1'b0
`define DIR_HOST_TO_CARD  1'b1
`define JUMPER_DEFAULT    6'h30

`endif

// ==== io_window_pkg.sv ====
// types for the io window decoder
// assumes io_window_defines.svh is on the include path
`include "io_window_defines.svh"

package io_window_pkg;

	// ==========================================================
	// host bus sample
	typedef struct packed {
		logic [`ADDR_WIDTH-1:0] addr;
		logic                   aen;
		logic                   read_n;
		logic                   write_n;
	} host_cycle_type;

	// four decoded strobes, active low
	typedef struct packed {
		logic read_strobe_window_n;
		logic write_strobe_window_n;
		logic strobe_window_1_n;
		logic strobe_window_0_n;
	} strobe_set_type;

	// decoder state
	typedef enum logic [1:0] {
		IDLE_STATE  = 2'b00,
		READ_STATE  = 2'b01,
		WRITE_STATE = 2'b10
	} access_state_type;

endpackage : io_window_pkg

// ==== io_window_decode_buffer.sv ====
// io window decoder: base match, strobes and data transceiver control for an 8-bit isa card
// assumes bus pins arrive asynchronous to i_clock; outputs lag the bus by about four cycles
`timescale 1ns/1ps
`include "io_window_defines.svh"

module io_window_decode_buffer
	import io_window_pkg::*;
#(
	parameter int ADDR_WIDTH = `ADDR_WIDTH
) (
	input  wire logic                    i_clock,
	input  wire logic                    i_arst_n,
	input  wire logic [ADDR_WIDTH-1:0]   i_addr,
	input  wire logic                    i_aen,
	input  wire logic                    i_ior_n,
	input  wire logic                    i_iow_n,
	input  wire logic [`JUMPER_COUNT-1:0] i_base_jumper_block,
	input  wire logic [7:0]              i_host_data,
	input  wire logic [7:0]              i_card_data,
	output logic [7:0]                   o_host_data,
	output logic                         o_host_data_oe,
	output logic [7:0]                   o_card_data,
	output logic                         o_card_data_oe,
	output logic                         o_card_select_n,
	output strobe_set_type               o_strobes,
	output logic                         o_xcvr_enable_n,
	output logic                         o_xcvr_dir
);

	// ==========================================================
	// input synchronisers
	host_cycle_type                    sync_a;
	host_cycle_type                    sync_b;
	logic [`JUMPER_COUNT-1:0]          jump_a;
	logic [`JUMPER_COUNT-1:0]          jump_b;
	host_cycle_type                    bus_in;

	assign bus_in = '{addr: i_addr, aen: i_aen, read_n: i_ior_n, write_n: i_iow_n};

	// two flops on every address, aen, strobe and jumper pin
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_a <= '{addr: '0, aen: 1'b1, read_n: 1'b1, write_n: 1'b1};
			sync_b <= '{addr: '0, aen: 1'b1, read_n: 1'b1, write_n: 1'b1};
			jump_a <= `JUMPER_DEFAULT;
			jump_b <= `JUMPER_DEFAULT;
		end else begin
			sync_a <= bus_in;
			sync_b <= sync_a;
			jump_a <= i_base_jumper_block;
			jump_b <= jump_a;
		end
	end

	// ==========================================================
	// base compare and cycle classification
	logic [`JUMPER_COUNT-1:0] base_field;
	logic [1:0]               slot;
	logic                     hit;
	logic                     is_read;
	logic                     is_write;

	// jumper weight sum
	// jumper bit k weighs 0x010 << k, so the weight sum is the address field itself
	assign base_field = sync_b.addr[`BASE_FIELD_MSB:`BASE_FIELD_LSB];
	assign slot       = sync_b.addr[`SLOT_FIELD_MSB:`SLOT_FIELD_LSB];

	assign hit      = (base_field == jump_b) && !sync_b.aen;
	assign is_read  = hit && !sync_b.read_n && sync_b.write_n;
	assign is_write = hit && !sync_b.write_n && sync_b.read_n;

	// ==========================================================
	// access state
	access_state_type state;
	access_state_type next_state;
	logic [1:0]       slot_q;
	logic [1:0]       next_slot_q;

	// state follows the synchronised strobes
	always_comb begin
		next_state  = IDLE_STATE;
		next_slot_q = slot_q;
		unique case (1'b1)
			is_read: begin
				next_state  = READ_STATE;
				next_slot_q = slot;
			end
			is_write: begin
				next_state  = WRITE_STATE;
				next_slot_q = slot;
			end
			default: begin
				next_state = IDLE_STATE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state  <= IDLE_STATE;
			slot_q <= `SLOT_WIN0;
		end else begin
			state  <= next_state;
			slot_q <= next_slot_q;
		end
	end

	// ==========================================================
	// outputs
	logic           active;
	logic           rd;
	logic           wr;
	strobe_set_type next_strobes;
	logic           next_card_select_n;
	logic           next_xcvr_enable_n;
	logic           next_xcvr_dir;

	assign active = (state != IDLE_STATE);
	assign rd     = (state == READ_STATE);
	assign wr     = (state == WRITE_STATE);

	always_comb begin
		next_strobes = '1;
		next_strobes.strobe_window_0_n     = !(active && slot_q == `SLOT_WIN0);
		next_strobes.strobe_window_1_n     = !(active && slot_q == `SLOT_WIN1);
		next_strobes.write_strobe_window_n = !(wr && slot_q == `SLOT_WRITE);
		next_strobes.read_strobe_window_n  = !(rd && slot_q == `SLOT_READ);
		next_card_select_n = !active;
		next_xcvr_enable_n = !active;
		next_xcvr_dir      = rd ? `DIR_CARD_TO_HOST : `DIR_HOST_TO_CARD;
	end

	// registered controls, flop outputs
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_strobes       <= '1;
			o_card_select_n <= 1'b1;
			o_xcvr_enable_n <= 1'b1;
			o_xcvr_dir      <= `DIR_HOST_TO_CARD;
		end else begin
			o_strobes       <= next_strobes;
			o_card_select_n <= next_card_select_n;
			o_xcvr_enable_n <= next_xcvr_enable_n;
			o_xcvr_dir      <= next_xcvr_dir;
		end
	end

	// ==========================================================
	// transceiver model: data passes straight through, enables follow gate and way
	// float unless accessed
	assign o_host_data    = i_card_data;
	assign o_card_data    = i_host_data;
	assign o_host_data_oe = !o_xcvr_enable_n && (o_xcvr_dir == `DIR_CARD_TO_HOST);
	assign o_card_data_oe = !o_xcvr_enable_n && (o_xcvr_dir == `DIR_HOST_TO_CARD);

	// ==========================================================
	// checks
	sequence s_read_hit;
		is_read;
	endsequence

	sequence s_write_hit;
		is_write;
	endsequence

	a_select_on_hit: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		hit && (is_read || is_write) |-> ##2 !o_card_select_n)
		else $error("card select missing after window hit");

	a_no_select_aen: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		sync_b.aen [*3] |-> o_card_select_n && (o_strobes == '1))
		else $error("select or strobe during aen cycle");

	a_base_mismatch: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(base_field != jump_b) [*3] |-> o_xcvr_enable_n)
		else $error("transceiver on without base match");

	a_read_dir_low: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		s_read_hit ##1 is_read |-> ##1 (o_xcvr_dir == 1'b0) && !o_xcvr_enable_n)
		else $error("read did not set way low");

	a_write_dir_high: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		s_write_hit ##1 is_write |-> ##1 (o_xcvr_dir == 1'b1) && !o_xcvr_enable_n)
		else $error("write did not set way high");

	a_write_only_slot: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		!o_strobes.write_strobe_window_n |-> $past(is_write, 2) && o_xcvr_dir)
		else $error("write strobe outside a write");

	a_read_only_slot: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		is_read && slot == `SLOT_READ |-> ##2 !o_strobes.read_strobe_window_n)
		else $error("read strobe missing");

	a_float_idle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(o_host_data_oe |-> $past(is_read, 2)) and (o_card_data_oe |-> $past(is_write, 2)))
		else $error("data driven outside access");

	a_one_strobe: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(o_strobes != '1) |-> $onehot0(~o_strobes) && !o_card_select_n)
		else $error("strobe without select");

endmodule : io_window_decode_buffer

// ==== io_host_model.sv ====
// host bus master model: drives isa i/o cycles into the window decoder
// assumes the bench calls io_start then io_stop from one process
`timescale 1ns/1ps

module io_host_model
	import io_window_pkg::*;
(
	input  wire logic     i_clock,
	output host_cycle_type o_bus,
	output logic [7:0]    o_host_data
);
	// ==========================================================
	// bus model
	// idle bus from time zero
	initial begin
		o_bus = '{addr: 10'h000, aen: 1'b0, read_n: 1'b1, write_n: 1'b1};
		o_host_data = 8'h00;
	end

	// address and aen settle before the strobe and hold
	task automatic io_start(input logic [9:0] addr, input logic aen, input logic rd);
		@(posedge i_clock);
		#1;
		o_bus.addr = addr;
		o_bus.aen = aen;
		@(posedge i_clock);
		#1;
		o_bus.read_n = !rd;
		o_bus.write_n = rd;
		o_host_data = rd ? ~o_host_data : 8'ha5;
	endtask : io_start

	// strobe ends first; released lines then show inverted values
	task automatic io_stop;
		@(posedge i_clock);
		#1;
		o_bus.read_n = 1'b1;
		o_bus.write_n = 1'b1;
		@(posedge i_clock);
		#1;
		o_bus.addr = ~o_bus.addr;
		o_host_data = ~o_host_data;
	endtask : io_stop
endmodule : io_host_model

// ==== io_window_decode_buffer_tb_top.sv ====
// bench for the io window decoder: host model drives cycles, all outputs judged
// assumes outputs follow the bus pins within four clocks
`timescale 1ns/1ps

module io_window_decode_buffer_tb_top
	import io_window_pkg::*;
;
	logic           i_clock = 1'b0;
	logic           i_arst_n = 1'b0;
	logic [5:0]     jumpers = 6'h30;
	host_cycle_type bus;
	logic [7:0]     host_data;
	logic [7:0]     card_data = 8'h5a;
	logic [7:0]     host_q;
	logic [7:0]     card_q;
	logic           host_oe;
	logic           card_oe;
	logic           card_select_n;
	strobe_set_type strobes;
	logic           xcvr_enable_n;
	logic           xcvr_dir;
	int             error_cnt = 0;
	int             n_compared = 0;
	wire  [8:0]     status = {card_select_n, strobes, xcvr_enable_n, xcvr_dir, host_oe, card_oe};

	// ==========================================================
	// clock and instances
	always #4 i_clock = ~i_clock;

	io_host_model i_io_host_model (.i_clock(i_clock), .o_bus(bus), .o_host_data(host_data));

	io_window_decode_buffer i_io_window_decode_buffer (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(bus.addr), .i_aen(bus.aen),
		.i_ior_n(bus.read_n), .i_iow_n(bus.write_n), .i_base_jumper_block(jumpers),
		.i_host_data(host_data), .i_card_data(card_data), .o_host_data(host_q),
		.o_host_data_oe(host_oe), .o_card_data(card_q), .o_card_data_oe(card_oe),
		.o_card_select_n(card_select_n), .o_strobes(strobes),
		.o_xcvr_enable_n(xcvr_enable_n), .o_xcvr_dir(xcvr_dir));

	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one cycle: judged mid-strobe and again once idle
	task automatic io_access(input logic [9:0] addr, input logic aen, input logic rd,
		input logic hit);
		logic [3:0] stb;
		stb = 4'hf;
		card_data = addr[7:0] ^ 8'h5a;
		if (hit) stb[addr[3:2]] = (addr[3:2] == 2'h2 && rd) || (addr[3:2] == 2'h3 && !rd);
		i_io_host_model.io_start(addr, aen, rd);
		repeat (6) @(posedge i_clock);
		#1;
		chk("status", {!hit, stb, !hit, !(hit && rd), hit && rd, hit && !rd}, status);
		if (hit) chk("data", 9'(rd ? (addr[7:0] ^ 8'h5a) : 8'ha5), 9'(rd ? host_q : card_q));
		i_io_host_model.io_stop;
		repeat (6) @(posedge i_clock);
		#1;
		chk("idle", 9'h1fc, status);
	endtask : io_access

	// ==========================================================
	// scenarios
	// every offset read and written, edges of window
	task automatic t_default_window;
		for (int i = 0; i < 32; i++) begin
			io_access(10'h300 + 10'(i % 16), 1'b0, i < 16, 1'b1);
		end
		io_access(10'h2ff, 1'b0, 1'b1, 1'b0);
		io_access(10'h310, 1'b0, 1'b0, 1'b0);
	endtask : t_default_window

	// each jumper weight alone, plus a miss with every base bit inverted
	task automatic t_jumper_weights;
		for (int k = 0; k < 6; k++) begin
			jumpers = 6'h01 << k;
			repeat (4) @(posedge i_clock);
			io_access((10'h010 << k) + 10'h00c, 1'b0, 1'b1, 1'b1);
			io_access((10'h010 << k) ^ 10'h3f0, 1'b0, 1'b0, 1'b0);
		end
		jumpers = 6'h30;
		repeat (4) @(posedge i_clock);
	endtask : t_jumper_weights

	task automatic t_aen_ignored;
		io_access(10'h308, 1'b1, 1'b0, 1'b0);
		io_access(10'h30c, 1'b1, 1'b1, 1'b0);
	endtask : t_aen_ignored

	task automatic test_done;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (6) @(posedge i_clock);
		#1;
		i_arst_n = 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		chk("reset", 9'h1fc, status);
		t_default_window;
		t_jumper_weights;
		t_aen_ignored;
		test_done;
	end

	initial begin
		#50000;
		error_cnt++;
		test_done;
	end
endmodule : io_window_decode_buffer_tb_top
